// ===== logic/vms_mode_select_decode.sv
`timescale 1ns/100ps
module vms_mode_select_decode #(
    parameter logic [7:0] STEP_SIZE = vms_pkg::STEP_LVL,
    parameter int STEP_CYCLES = vms_pkg::STEP_CYC
) (
    input wire logic MCLK,                     // 40 MHz clock
    input wire logic RST_N,                    // Async reset, active low
    input wire logic ENABLE,                   // Enable pin
    input wire logic MODE_SELECT_PIN,          // Mode select pin
    input wire logic [5:0] PARALLEL_CODE_BITS, // Parallel code pins
    input wire logic SERIAL_CLOCK_IN,          // Serial clock pin
    input wire logic SERIAL_DATA_IN,           // Serial data pin
    input wire logic HOST_POWER_OK,            // Host power ok pin
    input wire logic FIXED_CODE_ENABLE,        // Fixed code strap
    output logic PARALLEL_CODE_MODE,           // High in parallel mode
    output logic CORE_ENABLE,                  // Core regulator enable
    output logic BRIDGE_ENABLE,                // Bridge regulator enable
    output logic [7:0] CORE_REF_LEVEL,         // Core reference, 12.5 mV units
    output logic [7:0] BRIDGE_REF_LEVEL,       // Bridge reference, 12.5 mV units
    output logic PLANES_POWER_GOOD             // Enabled planes in regulation; core plane only in parallel mode
);
    // =========================================
    // Input synchronisers
    // =========================================
    localparam int SYN_W = 11;
    logic [SYN_W-1:0] pins_raw, syn1_q, syn2_q;
    assign pins_raw = {ENABLE, MODE_SELECT_PIN, PARALLEL_CODE_BITS, SERIAL_CLOCK_IN,
                       SERIAL_DATA_IN, FIXED_CODE_ENABLE};
    logic pok1_q, pok2_q;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            syn1_q <= '0;
            syn2_q <= '0;
            pok1_q <= 1'b0;
            pok2_q <= 1'b0;
        end else begin
            syn1_q <= pins_raw;
            syn2_q <= syn1_q;
            pok1_q <= HOST_POWER_OK;
            pok2_q <= pok1_q;
        end
    end
    logic en_s, sel_s, svc_s, svd_s, fix_s;
    logic [5:0] par_s;
    assign {en_s, sel_s, par_s, svc_s, svd_s, fix_s} = syn2_q;

    // =========================================
    // Decoders
    // =========================================
    function automatic logic [7:0] par_decode(input logic [5:0] code);
        logic [7:0] c;
        c = {3'h0, code[4:0]};
        if (code[vms_pkg::PAR_RANGE_BIT])
            par_decode = vms_pkg::LVL_P_LO_TOP - c;
        else
            par_decode = vms_pkg::LVL_P_HI_TOP - 8'(c << 1);
    endfunction

    function automatic logic [7:0] ser_decode(input logic fixed, input logic [1:0] pins);
        logic [7:0] r;
        r = vms_pkg::LVL_0V8;
        if (fixed) begin
            unique case (pins)
                2'h0: r = vms_pkg::LVL_1V4;
                2'h1: r = vms_pkg::LVL_1V2;
                2'h2: r = vms_pkg::LVL_1V0;
                2'h3: r = vms_pkg::LVL_0V8;
            endcase
        end else begin
            unique case (pins)
                2'h0: r = vms_pkg::LVL_1V1;
                2'h1: r = vms_pkg::LVL_1V0;
                2'h2: r = vms_pkg::LVL_0V9;
                2'h3: r = vms_pkg::LVL_0V8;
            endcase
        end
        ser_decode = r;
    endfunction

    wire logic [7:0] par_level = par_decode(par_s);
    wire logic [7:0] ser_level = ser_decode(fix_s, {svc_s, svd_s});

    // =========================================
    // Mode and holding register
    // =========================================
    logic en_d_q, par_mode_q;
    logic [7:0] hold_q;
    wire logic en_rise = en_s && !en_d_q;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            en_d_q <= 1'b0;
            par_mode_q <= 1'b0;
            hold_q <= vms_pkg::LVL_ZERO;
        end else begin
            en_d_q <= en_s;
            if (en_rise) begin
                par_mode_q <= sel_s;
                hold_q <= ser_level;
            end
        end
    end

    // Parallel code and fixed straps are followed live, else the held startup level is used whatever power-ok is
    wire logic [7:0] target = par_mode_q ? par_level :
                              fix_s ? ser_level :
                              hold_q;

    // =========================================
    // Soft-start / ramp sequencer
    // =========================================
    vms_pkg::vms_state_t state_q, state_d;
    logic [7:0] ref_q, ref_d;
    logic [vms_pkg::STEP_CNT_W-1:0] tick_q;
    wire logic tick = (tick_q == vms_pkg::STEP_CNT_W'(STEP_CYCLES - 1));
    wire logic at_target = (ref_q == target);
    wire logic [8:0] up_sum = {1'b0, ref_q} + {1'b0, STEP_SIZE};
    wire logic [7:0] step_up = (up_sum[7:0] > target || up_sum[8]) ? target : up_sum[7:0];
    // Ramp-down always reaches zero, even if enable returns meanwhile
    wire logic [7:0] step_dn_to = (en_s && (state_q != vms_pkg::VMS_RAMP_DOWN)) ? target :
                                  vms_pkg::LVL_ZERO;
    wire logic [7:0] step_dn = (ref_q < step_dn_to + STEP_SIZE) ? step_dn_to
                                                                : ref_q - STEP_SIZE;

    always_comb begin
        state_d = state_q;
        ref_d = ref_q;
        unique case (state_q)
            vms_pkg::VMS_OFF: begin
                ref_d = vms_pkg::LVL_ZERO;
                if (en_s && en_d_q)
                    state_d = vms_pkg::VMS_RAMP_UP;
            end
            vms_pkg::VMS_RAMP_UP: begin
                if (!en_s)
                    state_d = vms_pkg::VMS_RAMP_DOWN;
                else if (at_target)
                    state_d = vms_pkg::VMS_REGULATE;
                else if (tick)
                    ref_d = (ref_q < target) ? step_up : step_dn;
            end
            vms_pkg::VMS_REGULATE: begin
                if (!en_s)
                    state_d = vms_pkg::VMS_RAMP_DOWN;
                else if (tick && !at_target)
                    ref_d = (ref_q < target) ? step_up : step_dn;
            end
            vms_pkg::VMS_RAMP_DOWN: begin
                if (ref_q == vms_pkg::LVL_ZERO)
                    state_d = vms_pkg::VMS_OFF;
                else if (tick)
                    ref_d = step_dn;
            end
        endcase
        if (!en_s)
            ref_d = (state_q == vms_pkg::VMS_OFF) ? vms_pkg::LVL_ZERO :
                    (tick ? step_dn : ref_q);
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= vms_pkg::VMS_OFF;
            ref_q <= vms_pkg::LVL_ZERO;
            tick_q <= '0;
        end else begin
            state_q <= state_d;
            ref_q <= ref_d;
            tick_q <= tick ? '0 : tick_q + 1'b1;
        end
    end

    // =========================================
    // Outputs
    // =========================================
    wire logic active = en_s && (state_q != vms_pkg::VMS_OFF) &&
                        (state_q != vms_pkg::VMS_RAMP_DOWN);
    logic pg_q, core_en_q, br_en_q, pmode_q;
    logic [7:0] core_ref_q, br_ref_q;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            pg_q <= 1'b0;
            core_en_q <= 1'b0;
            br_en_q <= 1'b0;
            pmode_q <= 1'b0;
            core_ref_q <= vms_pkg::LVL_ZERO;
            br_ref_q <= vms_pkg::LVL_ZERO;
        end else begin
            pg_q <= en_s && (state_d == vms_pkg::VMS_REGULATE);
            core_en_q <= active || (state_q == vms_pkg::VMS_RAMP_DOWN);
            br_en_q <= (active || (state_q == vms_pkg::VMS_RAMP_DOWN)) && !par_mode_q;
            pmode_q <= par_mode_q;
            core_ref_q <= ref_d;
            br_ref_q <= par_mode_q ? vms_pkg::LVL_ZERO : ref_d;
        end
    end
    assign PLANES_POWER_GOOD = pg_q;
    assign CORE_ENABLE = core_en_q;
    assign BRIDGE_ENABLE = br_en_q;
    assign PARALLEL_CODE_MODE = pmode_q;
    assign CORE_REF_LEVEL = core_ref_q;
    assign BRIDGE_REF_LEVEL = br_ref_q;

    // =========================================
    // Checks
    // =========================================
    mode_capture_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        en_rise |=> par_mode_q == $past(sel_s))
        else $error("mode not captured at enable rise");
    mode_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (en_s && en_d_q) |=> $stable(par_mode_q))
        else $error("mode changed while enabled");
    off_idle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!en_s && state_q == vms_pkg::VMS_OFF) |=> !CORE_ENABLE && !BRIDGE_ENABLE)
        else $error("regulator on while disabled");
    bridge_off_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        par_mode_q |=> !BRIDGE_ENABLE && BRIDGE_REF_LEVEL == 8'h00)
        else $error("bridge active in parallel mode");
    pg_drop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !en_s |=> !PLANES_POWER_GOOD)
        else $error("power good held without enable");
    pg_target_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        $rose(PLANES_POWER_GOOD) |-> CORE_REF_LEVEL == $past(target))
        else $error("power good before target reached");
    ramp_step_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (state_q == vms_pkg::VMS_RAMP_UP && en_s && !tick) |=> $stable(ref_q))
        else $error("reference moved between steps");
    hold_latch_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        en_rise |=> hold_q == $past(ser_level))
        else $error("startup code not held");
    par_decode_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (par_s == 6'h1F) |-> par_level == 8'h3E)
        else $error("parallel decode wrong");
    hold_revert_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!par_mode_q && !fix_s && !pok2_q) |-> target == hold_q)
        else $error("serial target left holding level");
endmodule

// ===== logic/vms_pkg.sv
package vms_pkg;
    // Reference levels are in units of 12.5 mV
    localparam int LVL_W = 8;
    localparam logic [7:0] LVL_P_HI_TOP = 8'h7C;   // 1.5500 V
    localparam logic [7:0] LVL_P_LO_TOP = 8'h3D;   // 0.7625 V
    localparam logic [7:0] LVL_ZERO = 8'h00;
    localparam logic [7:0] LVL_1V4 = 8'h70;
    localparam logic [7:0] LVL_1V2 = 8'h60;
    localparam logic [7:0] LVL_1V1 = 8'h58;
    localparam logic [7:0] LVL_1V0 = 8'h50;
    localparam logic [7:0] LVL_0V9 = 8'h48;
    localparam logic [7:0] LVL_0V8 = 8'h40;
    localparam int PAR_RANGE_BIT = 5;
    localparam logic [7:0] STEP_LVL = 8'h01;
    // Step period in ns, cycles derived at 40 MHz
    localparam int CLK_PERIOD_NS = 25;
    localparam int STEP_TIME_NS = 1000;
    localparam int STEP_CYC = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CNT_W = 12;
    typedef enum logic [1:0] {
        VMS_OFF = 2'h0,
        VMS_RAMP_UP = 2'h1,
        VMS_REGULATE = 2'h3,
        VMS_RAMP_DOWN = 2'h2
    } vms_state_t;
endpackage

// ===== verif/test_vms_mode_select_decode.sv
`timescale 1ns/100ps
module test_vms_mode_select_decode;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic en_req = 1'b0, sel_req = 1'b0, fix_req = 1'b0, pok_req = 1'b1;
    logic [5:0] code_req = 6'h00;
    logic [1:0] pins_req = 2'h0;
    logic ENABLE, MODE_SELECT_PIN, SERIAL_CLOCK_IN, SERIAL_DATA_IN;
    logic HOST_POWER_OK, FIXED_CODE_ENABLE, PARALLEL_CODE_MODE;
    logic CORE_ENABLE, BRIDGE_ENABLE, PLANES_POWER_GOOD;
    logic [5:0] PARALLEL_CODE_BITS;
    logic [7:0] CORE_REF_LEVEL, BRIDGE_REF_LEVEL;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] start_lvl [4] = '{8'h58, 8'h50, 8'h48, 8'h40};
    logic [7:0] fix_lvl [4] = '{8'h70, 8'h60, 8'h50, 8'h40};
    logic [5:0] par_codes [6] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h21, 6'h3F};

    vms_host_model host_u (.MCLK(MCLK), .en_req(en_req), .sel_req(sel_req),
        .code_req(code_req), .pins_req(pins_req), .fix_req(fix_req), .pok_req(pok_req),
        .ENABLE(ENABLE), .MODE_SELECT_PIN(MODE_SELECT_PIN),
        .PARALLEL_CODE_BITS(PARALLEL_CODE_BITS), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
        .SERIAL_DATA_IN(SERIAL_DATA_IN), .FIXED_CODE_ENABLE(FIXED_CODE_ENABLE),
        .HOST_POWER_OK(HOST_POWER_OK));
    vms_mode_select_decode #(.STEP_CYCLES(2)) dut_u (.MCLK(MCLK), .RST_N(RST_N),
        .ENABLE(ENABLE), .MODE_SELECT_PIN(MODE_SELECT_PIN),
        .PARALLEL_CODE_BITS(PARALLEL_CODE_BITS), .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
        .SERIAL_DATA_IN(SERIAL_DATA_IN), .HOST_POWER_OK(HOST_POWER_OK),
        .FIXED_CODE_ENABLE(FIXED_CODE_ENABLE), .PARALLEL_CODE_MODE(PARALLEL_CODE_MODE),
        .CORE_ENABLE(CORE_ENABLE), .BRIDGE_ENABLE(BRIDGE_ENABLE),
        .CORE_REF_LEVEL(CORE_REF_LEVEL), .BRIDGE_REF_LEVEL(BRIDGE_REF_LEVEL),
        .PLANES_POWER_GOOD(PLANES_POWER_GOOD));

    initial forever #12.5 MCLK = ~MCLK;

    // ==========================================
    // Shared tasks
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task power_up(input logic sel, input logic [5:0] code, input logic [1:0] pins,
                  input logic fix);
        logic [7:0] prev;
        int n;
        @(negedge MCLK);
        sel_req <= sel;
        code_req <= code;
        pins_req <= pins;
        fix_req <= fix;
        en_req <= 1'b1;
        prev = 8'h00;
        n = 0;
        while (PLANES_POWER_GOOD !== 1'b1 && n < 600) begin
            @(negedge MCLK);
            n++;
            if (CORE_REF_LEVEL > prev + 8'h01) check("ramp step", prev + 8'h01, CORE_REF_LEVEL);
            prev = CORE_REF_LEVEL;
        end
        check("power good", 8'h01, {7'h00, PLANES_POWER_GOOD});
    endtask

    task power_down;
        int n;
        @(negedge MCLK);
        en_req <= 1'b0;
        repeat (5) @(negedge MCLK);
        check("power good low", 8'h00, {7'h00, PLANES_POWER_GOOD});
        n = 0;
        while (CORE_ENABLE !== 1'b0 && n < 400) begin
            @(negedge MCLK);
            n++;
        end
        check("core ref down", 8'h00, CORE_REF_LEVEL);
        check("bridge ref down", 8'h00, BRIDGE_REF_LEVEL);
        check("regulators off", 8'h00, {6'h00, CORE_ENABLE, BRIDGE_ENABLE});
    endtask

    // ==========================================
    // Scenarios
    task t_parallel;
        logic [5:0] c;
        for (int i = 0; i < 6; i++) begin
            c = par_codes[i];
            power_up(1'b1, c, 2'h3, 1'b0);
            check("parallel mode", 8'h01, {7'h00, PARALLEL_CODE_MODE});
            check("core ref", c[5] ? 8'h3D - {3'h0, c[4:0]} : 8'h7C - {2'h0, c[4:0], 1'b0},
                  CORE_REF_LEVEL);
            check("core only", 8'h02, {6'h00, CORE_ENABLE, BRIDGE_ENABLE});
            check("bridge ref", 8'h00, BRIDGE_REF_LEVEL);
            power_down();
        end
        $display("test parallel finished");
    endtask

    task t_serial;
        for (int k = 0; k < 4; k++) begin
            power_up(1'b0, 6'h3F, 2'(k), 1'b0);
            check("serial mode", 8'h00, {7'h00, PARALLEL_CODE_MODE});
            check("core startup", start_lvl[k], CORE_REF_LEVEL);
            check("bridge startup", start_lvl[k], BRIDGE_REF_LEVEL);
            check("both on", 8'h03, {6'h00, CORE_ENABLE, BRIDGE_ENABLE});
            if (k == 3) begin
                sel_req <= 1'b1;
                pins_req <= 2'h0;
                pok_req <= 1'b0;
                repeat (20) @(negedge MCLK);
                check("mode held", 8'h00, {7'h00, PARALLEL_CODE_MODE});
                check("level held", start_lvl[3], CORE_REF_LEVEL);
                pok_req <= 1'b1;
            end
            power_down();
        end
        $display("test serial finished");
    endtask

    task t_fixed;
        int n;
        for (int k = 0; k < 4; k++) begin
            power_up(1'b0, 6'h00, 2'(k), 1'b1);
            check("core fixed", fix_lvl[k], CORE_REF_LEVEL);
            check("bridge fixed", fix_lvl[k], BRIDGE_REF_LEVEL);
            pins_req <= 2'(k + 1);
            n = 0;
            while (CORE_REF_LEVEL !== fix_lvl[(k + 1) % 4] && n < 300) begin
                @(negedge MCLK);
                n++;
            end
            check("strap follow", fix_lvl[(k + 1) % 4], CORE_REF_LEVEL);
            power_down();
        end
        $display("test fixed finished");
    endtask

    initial begin
        repeat (4) @(posedge MCLK);
        @(negedge MCLK);
        check("off in reset", 8'h00, {6'h00, CORE_ENABLE, BRIDGE_ENABLE});
        RST_N = 1'b1;
        t_parallel();
        t_serial();
        t_fixed();
        complete_run();
    end

    initial begin
        #1000000;
        error_cnt++;
        $display("watchdog expired");
        complete_run();
    end
endmodule

// ===== verif/vms_host_model.sv
`timescale 1ns/100ps
// ==========================================
// Processor pins and board strap jumpers
module vms_host_model (
    input wire logic MCLK,                  // Bench clock
    input wire logic en_req,                // Enable wanted
    input wire logic sel_req,               // Select level wanted
    input wire logic [5:0] code_req,        // Parallel code wanted
    input wire logic [1:0] pins_req,        // Clock and data pin levels
    input wire logic fix_req,               // Fixed strap level
    input wire logic pok_req,               // Power ok level
    output logic ENABLE,                    // Enable pin
    output logic MODE_SELECT_PIN,           // Select pin
    output logic [5:0] PARALLEL_CODE_BITS,  // Code pins
    output logic SERIAL_CLOCK_IN,           // Clock pin
    output logic SERIAL_DATA_IN,            // Data pin
    output logic FIXED_CODE_ENABLE,         // Fixed strap
    output logic HOST_POWER_OK              // Power ok pin
);
    int stable_cnt = 0;
    logic sel_q = 1'b0;
    initial ENABLE = 1'b0;
    assign MODE_SELECT_PIN = sel_req;
    assign PARALLEL_CODE_BITS = code_req;
    assign {SERIAL_CLOCK_IN, SERIAL_DATA_IN} = pins_req;
    assign FIXED_CODE_ENABLE = fix_req;
    assign HOST_POWER_OK = pok_req;
    // Enable held back until select has stood 1 us
    always @(negedge MCLK) begin
        sel_q <= sel_req;
        stable_cnt <= (sel_req != sel_q) ? 0 : stable_cnt + 1;
        ENABLE <= en_req && (ENABLE || (sel_req == sel_q && stable_cnt >= 40));
    end
endmodule
